// >>> common/prs_consts.svh
// Constants of the program counter and return stack block.
// Included by the package and the design module.
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

// Widths
`define PRS_PC_W        21
`define PRS_PTR_W       5
`define PRS_DEPTH       31
`define PRS_PTR_MAX     5'h1F
`define PRS_PTR_PRE     5'h1E
`define PRS_PTR_EMPTY   5'h00
`define PRS_PC_STEP     21'h000002
`define PRS_PC_ZERO     21'h000000

// Register byte offsets
`define PRS_OFS_PCL     8'h00
`define PRS_OFS_LATH    8'h04
`define PRS_OFS_LATU    8'h08
`define PRS_OFS_TOP_ENTRY_LOW    8'h0C
`define PRS_OFS_TOP_ENTRY_HIGH    8'h10
`define PRS_OFS_TOP_ENTRY_UPPER    8'h14
`define PRS_OFS_SPTR    8'h18
`define PRS_OFS_CFG     8'h1C

// Stack pointer register fields
`define PRS_SP_FULL_BIT 7
`define PRS_SP_UNF_BIT  6

// Configuration register fields and reset values
`define PRS_CFG_RSTEN_BIT 0
`define PRS_RSTEN_RESET   1'b1

`endif

// >>> common/prs_pkg.sv
// Types of the program counter and return stack block.
// Assumes prs_consts.svh is on the include path.
`include "prs_consts.svh"

package prs_pkg;

    // Core command codes
    typedef enum logic [2:0] {
        PRS_OP_NONE = 3'h0,
        PRS_OP_SEQ  = 3'h1,
        PRS_OP_JUMP = 3'h3,
        PRS_OP_CALL = 3'h2,
        PRS_OP_RET  = 3'h6,
        PRS_OP_PUSH = 3'h7,
        PRS_OP_POP  = 3'h5,
        PRS_OP_IACK = 3'h4
    } prs_op_e;

    // Command from the decode and execute logic
    typedef struct packed {
        prs_op_e                 op;
        logic [`PRS_PC_W-1:0]    target;
    } prs_cmd_s;

    // Status seen by the core
    typedef struct packed {
        logic [`PRS_PC_W-1:0]    pc;
        logic [`PRS_PTR_W-1:0]   ptr;
        logic                    full;
        logic                    unf;
    } prs_stat_s;

    // State of the block except the stack storage
    typedef struct packed {
        logic [`PRS_PC_W-1:0]    pc;
        logic [7:0]              lath;
        logic [4:0]              latu;
        logic [`PRS_PTR_W-1:0]   ptr;
        logic                    full;
        logic                    unf;
        logic                    rst_en;
        logic                    rst_req;
        logic                    ack;
        logic [7:0]              rdat;
    } prs_state_s;

endpackage

// >>> rtl/prs_core.sv
// Program counter, counter latches and 31-entry return address stack.
// Assumes a 20 MHz clk, a synchronous power-on reset and classic
// Wishbone with 8-bit registers in the low lane of 32-bit words.
//
// Operation
// - A 21-bit byte program counter split into low, high and upper bytes.
// - Low byte is software readable and writable; high byte is not.
// - Upper byte is not directly accessible; loaded only via its latch.
// - Writing the low byte loads high and upper bytes from the latches.
// - Reading the low byte copies high and upper bytes into the latches.
// - Low-byte writes clear counter bit zero; jump, call and return loads do not; sequential fetch adds two.
// - Calls, goto and branches load the counter, ignoring the latches.
// - Stack is 31 words of 21 bits, 5-bit pointer, own storage.
// - Calls and interrupt acknowledges push the counter.
// - Returns pop into the counter; calls and returns leave latches alone.
// - Push increments the pointer, then writes the counter there.
// - Pop moves the addressed entry to the counter, then decrements.
// - Pointer is zero after every reset; zero has no storage entry.
// - Top-of-stack registers show and write only the addressed entry.
// - Software reads and writes the pointer, range 0 to 31.
// - Full flag sets after 31 pushes; cleared by software or power-on.
// - Reset option on: 31st push stores counter plus two, resets, pointer zero.
// - Reset option off: pointer stops at 31; later pushes write nothing.
// - Pop at zero loads zero, sets underflow, pointer stays zero.
// - Underflow flag holds until software clear or power-on reset.
// - Explicit push increments pointer and stores the current counter.
// - Explicit pop decrements the pointer, or at zero sets underflow; counter unchanged.
// - Pointer register: full bit 7, underflow bit 6, zero bit 5, pointer 4:0.
// - Reset option on: underflow also resets; off: flags only.
`timescale 1ns/10ps
`include "prs_consts.svh"

module prs_core (
    // Clock and resets
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  dev_rst,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // Core side
    input  prs_pkg::prs_cmd_s          cmd,
    output prs_pkg::prs_stat_s         stat,
    output logic                       reset_request
);

    // Stack storage, entries 1 to 31
    logic [`PRS_PC_W-1:0] stack_mem [1:`PRS_DEPTH];

    prs_pkg::prs_state_s  st_reg;
    prs_pkg::prs_state_s  st_next;

    logic                 mem_we;
    logic [4:0]           mem_adr;
    logic [`PRS_PC_W-1:0] mem_wdat;
    logic [`PRS_PC_W-1:0] tos_val;
    logic                 bus_req;
    logic                 bus_wr;
    logic                 bus_rd;
    logic                 lane0;
    logic [7:0]           wbyte;
    logic                 push_ev;
    logic                 pop_ev;
    logic                 full_set;
    logic                 unf_set;
    logic                 full_clr;
    logic                 unf_clr;
    logic                 sel_pcl;
    logic                 sel_lath;
    logic                 sel_latu;
    logic                 sel_top_entry_low;
    logic                 sel_top_entry_high;
    logic                 sel_top_entry_upper;
    logic                 sel_sptr;
    logic                 sel_cfg;
    logic                 tos_sel;
    logic [7:0]           rd_mux;
    logic [`PRS_PC_W-1:0] tos_wdat;
    logic [`PRS_PC_W-1:0] pc_seq;
    logic                 ptr_empty;
    logic                 ptr_top;
    logic                 ptr_pre;
    logic                 is_seq;
    logic                 is_jump;
    logic                 is_call;
    logic                 is_push;
    logic                 is_ret;
    logic                 is_pop;

    // Entry addressed by the pointer, zero when empty
    always_comb begin
        if (st_reg.ptr == `PRS_PTR_EMPTY) begin
            tos_val = `PRS_PC_ZERO;
        end else begin
            tos_val = stack_mem[st_reg.ptr];
        end
    end

    // Bus request decode
    always_comb begin
        bus_req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
        bus_wr  = bus_req & wb_we_i;
        bus_rd  = bus_req & ~wb_we_i;
        lane0   = wb_sel_i[0];
        wbyte   = wb_dat_i[7:0];
    end

    // Register select decode
    always_comb begin
        sel_pcl  = 1'b0;
        sel_lath = 1'b0;
        sel_latu = 1'b0;
        sel_top_entry_low = 1'b0;
        sel_top_entry_high = 1'b0;
        sel_top_entry_upper = 1'b0;
        sel_sptr = 1'b0;
        sel_cfg  = 1'b0;
        if (wb_adr_i == `PRS_OFS_PCL) begin
            sel_pcl = 1'b1;
        end else if (wb_adr_i == `PRS_OFS_LATH) begin
            sel_lath = 1'b1;
        end else if (wb_adr_i == `PRS_OFS_LATU) begin
            sel_latu = 1'b1;
        end else if (wb_adr_i == `PRS_OFS_TOP_ENTRY_LOW) begin
            sel_top_entry_low = 1'b1;
        end else if (wb_adr_i == `PRS_OFS_TOP_ENTRY_HIGH) begin
            sel_top_entry_high = 1'b1;
        end else if (wb_adr_i == `PRS_OFS_TOP_ENTRY_UPPER) begin
            sel_top_entry_upper = 1'b1;
        end else if (wb_adr_i == `PRS_OFS_SPTR) begin
            sel_sptr = 1'b1;
        end else if (wb_adr_i == `PRS_OFS_CFG) begin
            sel_cfg = 1'b1;
        end
        tos_sel = sel_top_entry_low | sel_top_entry_high | sel_top_entry_upper;
    end

    // Sequential address and pointer tests
    always_comb begin
        pc_seq    = st_reg.pc + `PRS_PC_STEP;
        ptr_empty = (st_reg.ptr == `PRS_PTR_EMPTY);
        ptr_top   = (st_reg.ptr == `PRS_PTR_MAX);
        ptr_pre   = (st_reg.ptr == `PRS_PTR_PRE);
    end

    // Top entry with one byte replaced
    always_comb begin
        if (sel_top_entry_low) begin
            tos_wdat = {tos_val[20:8], wbyte};
        end else if (sel_top_entry_high) begin
            tos_wdat = {tos_val[20:16], wbyte, tos_val[7:0]};
        end else if (sel_top_entry_upper) begin
            tos_wdat = {wbyte[4:0], tos_val[15:0]};
        end else begin
            tos_wdat = tos_val;
        end
    end

    // Register read data
    always_comb begin
        if (sel_pcl) begin
            rd_mux = st_reg.pc[7:0];
        end else if (sel_lath) begin
            rd_mux = st_reg.lath;
        end else if (sel_latu) begin
            rd_mux = {3'h0, st_reg.latu};
        end else if (sel_top_entry_low) begin
            rd_mux = tos_val[7:0];
        end else if (sel_top_entry_high) begin
            rd_mux = tos_val[15:8];
        end else if (sel_top_entry_upper) begin
            rd_mux = {3'h0, tos_val[20:16]};
        end else if (sel_sptr) begin
            rd_mux = {st_reg.full, st_reg.unf, 1'b0, st_reg.ptr};
        end else if (sel_cfg) begin
            rd_mux = {7'h00, st_reg.rst_en};
        end else begin
            rd_mux = 8'h00;
        end
    end

    // Command decode
    always_comb begin
        is_seq  = 1'b0;
        is_jump = 1'b0;
        is_call = 1'b0;
        is_push = 1'b0;
        is_ret  = 1'b0;
        is_pop  = 1'b0;
        case (cmd.op)
            prs_pkg::PRS_OP_SEQ: begin
                is_seq = 1'b1;
            end
            prs_pkg::PRS_OP_JUMP: begin
                is_jump = 1'b1;
            end
            prs_pkg::PRS_OP_CALL,
            prs_pkg::PRS_OP_IACK: begin
                is_call = 1'b1;
            end
            prs_pkg::PRS_OP_PUSH: begin
                is_push = 1'b1;
            end
            prs_pkg::PRS_OP_RET: begin
                is_ret = 1'b1;
            end
            prs_pkg::PRS_OP_POP: begin
                is_pop = 1'b1;
            end
            default: begin
                is_seq = 1'b0;
            end
        endcase
    end

    // Next state
    always_comb begin
        st_next  = st_reg;
        mem_we   = 1'b0;
        mem_adr  = st_reg.ptr;
        mem_wdat = st_reg.pc;
        push_ev  = 1'b0;
        pop_ev   = 1'b0;
        full_set = 1'b0;
        unf_set  = 1'b0;
        full_clr = 1'b0;
        unf_clr  = 1'b0;

        st_next.rst_req = 1'b0;
        st_next.ack     = bus_req;
        st_next.rdat    = 8'h00;

        // Core commands
        if (is_seq) begin
            st_next.pc = pc_seq;
        end else if (is_jump) begin
            st_next.pc = cmd.target;
        end else if (is_call) begin
            push_ev    = 1'b1;
            st_next.pc = cmd.target;
        end else if (is_push) begin
            push_ev = 1'b1;
        end else if (is_ret) begin
            pop_ev = 1'b1;
            if (ptr_empty) begin
                st_next.pc = `PRS_PC_ZERO;
            end else begin
                st_next.pc = tos_val;
            end
        end else if (is_pop) begin
            pop_ev = 1'b1;
        end

        // Push: increment, then write the new entry
        if (push_ev) begin
            if (ptr_top) begin
                full_set = 1'b1;
            end else begin
                mem_we   = 1'b1;
                mem_adr  = st_reg.ptr + 5'h01;
                mem_wdat = st_reg.pc;
                st_next.ptr = st_reg.ptr + 5'h01;
                if (ptr_pre) begin
                    full_set = 1'b1;
                    if (st_reg.rst_en) begin
                        mem_wdat    = st_reg.pc + `PRS_PC_STEP;
                        st_next.ptr = `PRS_PTR_EMPTY;
                    end
                end
            end
        end

        // Pop: decrement after the read
        if (pop_ev) begin
            if (st_reg.ptr == `PRS_PTR_EMPTY) begin
                unf_set = 1'b1;
            end else begin
                st_next.ptr = st_reg.ptr - 5'h01;
            end
        end

        // Reset request on stack error
        if ((full_set | unf_set) & st_reg.rst_en) begin
            st_next.rst_req = 1'b1;
        end

        // Register writes
        if (bus_wr & lane0) begin
            if (wb_adr_i == `PRS_OFS_PCL) begin
                st_next.pc = {st_reg.latu, st_reg.lath, wbyte[7:1], 1'b0};
            end else if (wb_adr_i == `PRS_OFS_LATH) begin
                st_next.lath = wbyte;
            end else if (wb_adr_i == `PRS_OFS_LATU) begin
                st_next.latu = wbyte[4:0];
            end else if (wb_adr_i == `PRS_OFS_TOP_ENTRY_LOW) begin
                if (!mem_we && st_reg.ptr != `PRS_PTR_EMPTY) begin
                    mem_we   = 1'b1;
                    mem_wdat = tos_wdat;
                end
            end else if (wb_adr_i == `PRS_OFS_TOP_ENTRY_HIGH) begin
                if (!mem_we && st_reg.ptr != `PRS_PTR_EMPTY) begin
                    mem_we   = 1'b1;
                    mem_wdat = tos_wdat;
                end
            end else if (wb_adr_i == `PRS_OFS_TOP_ENTRY_UPPER) begin
                if (!mem_we && st_reg.ptr != `PRS_PTR_EMPTY) begin
                    mem_we   = 1'b1;
                    mem_wdat = tos_wdat;
                end
            end else if (wb_adr_i == `PRS_OFS_SPTR) begin
                st_next.ptr = wbyte[4:0];
                full_clr    = ~wbyte[`PRS_SP_FULL_BIT];
                unf_clr     = ~wbyte[`PRS_SP_UNF_BIT];
            end else if (wb_adr_i == `PRS_OFS_CFG) begin
                st_next.rst_en = wbyte[`PRS_CFG_RSTEN_BIT];
            end else begin
                st_next.rst_en = st_reg.rst_en;
            end
        end

        // Flags: set wins over clear
        st_next.full = full_set | (st_reg.full & ~full_clr);
        st_next.unf  = unf_set | (st_reg.unf & ~unf_clr);

        // Register reads
        if (bus_rd) begin
            st_next.rdat = rd_mux;
            if (sel_pcl) begin
                st_next.lath = st_reg.pc[15:8];
                st_next.latu = st_reg.pc[20:16];
            end
        end

        // Device reset keeps flags and option
        if (dev_rst) begin
            st_next.pc      = `PRS_PC_ZERO;
            st_next.ptr     = `PRS_PTR_EMPTY;
            st_next.rst_req = 1'b0;
            mem_we          = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg         <= '0;
            st_reg.ptr     <= `PRS_PTR_EMPTY;
            st_reg.rst_en  <= `PRS_RSTEN_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Stack write port
    always_ff @(posedge clk) begin
        if (mem_we && mem_adr != `PRS_PTR_EMPTY) begin
            stack_mem[mem_adr] <= mem_wdat;
        end
    end

    // Outputs
    always_comb begin
        wb_dat_o      = {24'h000000, st_reg.rdat};
        wb_ack_o      = st_reg.ack;
        stat.pc       = st_reg.pc;
        stat.ptr      = st_reg.ptr;
        stat.full     = st_reg.full;
        stat.unf      = st_reg.unf;
        reset_request = st_reg.rst_req;
    end

endmodule

// >>> bench/prs_core_sva.sv
// Checker of the counter and return stack block.
// Bound to prs_core; sees its ports only.
`timescale 1ns/10ps
`include "prs_consts.svh"
module prs_core_sva (
    // Clock and resets
    input wire logic          clk,
    input wire logic          rstn,
    input wire logic          dev_rst,
    // Bus
    input wire logic          wb_cyc_i,
    input wire logic          wb_stb_i,
    input wire logic          wb_we_i,
    input wire logic [7:0]    wb_adr_i,
    input wire logic [31:0]   wb_dat_o,
    input wire logic          wb_ack_o,
    // Core side
    input prs_pkg::prs_cmd_s  cmd,
    input prs_pkg::prs_stat_s stat,
    input wire logic          reset_request
);
    logic take;
    logic quiet;
    logic push_cmd;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign push_cmd = (cmd.op == prs_pkg::PRS_OP_CALL || cmd.op == prs_pkg::PRS_OP_IACK
        || cmd.op == prs_pkg::PRS_OP_PUSH);
    assign quiet = !dev_rst && !(take && wb_we_i);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence bus_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence pushing;
        push_cmd;
    endsequence
    a_bus_ack_once: assert property (take |=> bus_answer) else $error("ack not one pulse");
    a_read_idle: assert property (wb_dat_o[31:8] == 24'h0 && (wb_ack_o || wb_dat_o == 32'h0)) else $error("idle data");
    a_pc_even: assert property (stat.pc[0] == 1'b0) else $error("pc odd");
    a_seq_step: assert property (cmd.op == prs_pkg::PRS_OP_SEQ && quiet |=> stat.pc == $past(stat.pc) + 21'h2)
        else $error("seq step");
    a_jump_loads: assert property ((cmd.op == prs_pkg::PRS_OP_JUMP || (push_cmd && cmd.op != prs_pkg::PRS_OP_PUSH
        && stat.ptr < 5'h1E)) && quiet |=> stat.pc == $past(cmd.target)) else $error("jump");
    a_push_ptr: assert property (pushing and quiet && stat.ptr < 5'h1E |=> stat.ptr == $past(stat.ptr) + 5'h1)
        else $error("push ptr");
    a_pop_ptr: assert property ((cmd.op == prs_pkg::PRS_OP_RET || cmd.op == prs_pkg::PRS_OP_POP) && stat.ptr != 5'h0
        && quiet |=> stat.ptr == $past(stat.ptr) - 5'h1) else $error("pop ptr");
    a_unf_return: assert property (cmd.op == prs_pkg::PRS_OP_RET && stat.ptr == 5'h0 && quiet
        |=> stat.pc == 21'h0 && stat.unf && stat.ptr == 5'h0) else $error("underflow");
    a_flags_hold: assert property ((stat.full || stat.unf) && !(take && wb_we_i && wb_adr_i == `PRS_OFS_SPTR)
        |=> (stat.full || !$past(stat.full)) && (stat.unf || !$past(stat.unf))) else $error("flag lost");
    a_req_pulse: assert property (reset_request |=> !reset_request) else $error("request long");
    a_dev_rst: assert property (dev_rst |=> stat.ptr == 5'h0 && stat.pc == 21'h0) else $error("dev reset");
endmodule

bind prs_core prs_core_sva u_sva (.clk(clk), .rstn(rstn), .dev_rst(dev_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cmd(cmd), .stat(stat), .reset_request(reset_request));

// >>> bench/prs_core_model.sv
// Model of the core decode and execute logic.
// Issues one command per call, idle between calls.
`timescale 1ns/10ps
module prs_core_model (
    // Clock
    input wire logic          clk,
    // Command out
    output prs_pkg::prs_cmd_s cmd
);
    initial cmd = '{op: prs_pkg::PRS_OP_NONE, target: 21'h0};
    task automatic issue(input prs_pkg::prs_op_e op, input logic [20:0] tgt);
        @(posedge clk);
        cmd <= '{op: op, target: {tgt[20:1], 1'b0}};
        @(posedge clk);
        cmd.op <= prs_pkg::PRS_OP_NONE;
        cmd.target <= ~cmd.target;
        #1;
    endtask
endmodule

// >>> bench/test_program_counter_return_stack.sv
// Testbench of the counter and return stack block.
// Drives Wishbone and the core model; needs prs_consts.svh.
`timescale 1ns/10ps
`include "prs_consts.svh"
module test_program_counter_return_stack;
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic               dev_rst = 1'b0;
    logic               cyc = 1'b0;
    logic               stb = 1'b0;
    logic               we = 1'b0;
    logic [7:0]         adr = 8'h00;
    logic [31:0]        wdat = 32'h0;
    logic [31:0]        rdat;
    logic               ack;
    logic               rreq;
    logic [7:0]         rr = 8'h00;
    prs_pkg::prs_cmd_s  cmd;
    prs_pkg::prs_stat_s stat;
    int                 mismatches = 0;
    int                 checks = 0;
    always #25 clk = ~clk;
    always @(posedge clk) if (rreq === 1'b1) rr <= rr + 8'h01;
    prs_core DUT (.clk(clk), .rstn(rstn), .dev_rst(dev_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cmd(cmd),
        .stat(stat), .reset_request(rreq));
    prs_core_model u_model (.clk(clk), .cmd(cmd));
    task automatic test_done();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: byte %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_pc(input logic [20:0] exp);
        checks++;
        #1;
        if (stat.pc !== exp) begin
            mismatches++;
            $display("wrong value at %0t: pc %h not %h", $time, stat.pc, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) mismatches++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        xfer(1'b0, a, 8'h00, r);
        chk_reg(r, exp);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(`PRS_OFS_SPTR, 8'h00);
        rd(`PRS_OFS_CFG, 8'h01);
        rd(8'h40, 8'h00);
        wr(`PRS_OFS_LATH, 8'h12);
        wr(`PRS_OFS_LATU, 8'h03);
        wr(`PRS_OFS_PCL, 8'h57);
        chk_pc(21'h031256);
        u_model.issue(prs_pkg::PRS_OP_SEQ, 21'h0);
        chk_pc(21'h031258);
        u_model.issue(prs_pkg::PRS_OP_JUMP, 21'h0ABCD0);
        chk_pc(21'h0ABCD0);
        rd(`PRS_OFS_LATH, 8'h12);
        rd(`PRS_OFS_PCL, 8'hD0);
        rd(`PRS_OFS_LATH, 8'hBC);
        rd(`PRS_OFS_LATU, 8'h0A);
        $display("test counter done");
        u_model.issue(prs_pkg::PRS_OP_CALL, 21'h001000);
        chk_pc(21'h001000);
        rd(`PRS_OFS_SPTR, 8'h01);
        rd(`PRS_OFS_TOP_ENTRY_LOW, 8'hD0);
        rd(`PRS_OFS_TOP_ENTRY_HIGH, 8'hBC);
        rd(`PRS_OFS_TOP_ENTRY_UPPER, 8'h0A);
        wr(`PRS_OFS_TOP_ENTRY_LOW, 8'h44);
        u_model.issue(prs_pkg::PRS_OP_IACK, 21'h000008);
        u_model.issue(prs_pkg::PRS_OP_RET, 21'h0);
        chk_pc(21'h001000);
        u_model.issue(prs_pkg::PRS_OP_RET, 21'h0);
        chk_pc(21'h0ABC44);
        rd(`PRS_OFS_LATH, 8'hBC);
        u_model.issue(prs_pkg::PRS_OP_RET, 21'h0);
        chk_pc(21'h0);
        rd(`PRS_OFS_SPTR, 8'h40);
        chk_reg(rr, 8'h01);
        wr(`PRS_OFS_SPTR, 8'hDF);
        rd(`PRS_OFS_SPTR, 8'h5F);
        wr(`PRS_OFS_SPTR, 8'h00);
        rd(`PRS_OFS_SPTR, 8'h00);
        $display("test call return done");
        u_model.issue(prs_pkg::PRS_OP_JUMP, 21'h000100);
        repeat (31) u_model.issue(prs_pkg::PRS_OP_PUSH, 21'h0);
        rd(`PRS_OFS_SPTR, 8'h80);
        chk_reg(rr, 8'h02);
        wr(`PRS_OFS_SPTR, 8'h9F);
        rd(`PRS_OFS_SPTR, 8'h9F);
        rd(`PRS_OFS_TOP_ENTRY_LOW, 8'h02);
        u_model.issue(prs_pkg::PRS_OP_POP, 21'h0);
        rd(`PRS_OFS_SPTR, 8'h9E);
        chk_pc(21'h000100);
        wr(`PRS_OFS_CFG, 8'h00);
        wr(`PRS_OFS_SPTR, 8'h00);
        repeat (31) u_model.issue(prs_pkg::PRS_OP_PUSH, 21'h0);
        u_model.issue(prs_pkg::PRS_OP_JUMP, 21'h000200);
        u_model.issue(prs_pkg::PRS_OP_PUSH, 21'h0);
        rd(`PRS_OFS_SPTR, 8'h9F);
        rd(`PRS_OFS_TOP_ENTRY_HIGH, 8'h01);
        wr(`PRS_OFS_SPTR, 8'h00);
        u_model.issue(prs_pkg::PRS_OP_POP, 21'h0);
        rd(`PRS_OFS_SPTR, 8'h40);
        chk_reg(rr, 8'h02);
        $display("test overflow done");
        wr(`PRS_OFS_SPTR, 8'h43);
        rd(`PRS_OFS_SPTR, 8'h43);
        @(posedge clk);
        dev_rst <= 1'b1;
        @(posedge clk);
        dev_rst <= 1'b0;
        rd(`PRS_OFS_SPTR, 8'h40);
        chk_pc(21'h0);
        $display("test device reset done");
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk);
        $display("wrong value at %0t: run hung", $time);
        mismatches++;
        test_done();
    end
endmodule
